// ---- core/fpc_map.vh ----
// Purpose: constants for the failure-prediction command handler
// Assumes: task-file offsets are byte addresses on the host port
// Notes:   counts derive from a 100 MHz clock
`ifndef FPC_MAP_VH
`define FPC_MAP_VH
`define FPC_OFF_FEATURE      10'h1f1
`define FPC_OFF_SECT_CNT     10'h1f2
`define FPC_OFF_SECT_NUM     10'h1f3
`define FPC_OFF_KEY_LOW      10'h1f4
`define FPC_OFF_KEY_HIGH     10'h1f5
`define FPC_OFF_DRV_HEAD     10'h1f6
`define FPC_OFF_COMMAND      10'h1f7
`define FPC_OFF_DATA         10'h1f0
`define FPC_CMD_FAIL_PRED    8'hb0
`define FPC_SUB_READ_ATTR    8'hd0
`define FPC_SUB_READ_THR     8'hd1
`define FPC_SUB_AUTOSAVE     8'hd2
`define FPC_SUB_SAVE_ATTR    8'hd3
`define FPC_SUB_ENABLE       8'hd8
`define FPC_SUB_DISABLE      8'hd9
`define FPC_SUB_STATUS       8'hda
`define FPC_KEY_LOW          8'h4f
`define FPC_KEY_HIGH         8'hc2
`define FPC_BAD_LOW          8'hf4
`define FPC_BAD_HIGH         8'h2c
`define FPC_ST_BSY_BIT       7
`define FPC_ST_DRDY_BIT      6
`define FPC_ST_DRQ_BIT       3
`define FPC_ST_ERR_BIT       0
`define FPC_ER_ABRT          8'h04
`define FPC_BLOCK_BYTES      10'h200
`define FPC_BLOCK_LAST       9'h1ff
`define FPC_ENTRY_FIRST      9'h002
`define FPC_ENTRY_LEN        4'hc
`define FPC_ENTRY_COUNT      5'h1e
`define FPC_ENTRY_END        9'h16a
`define FPC_AUTOSAVE_MIN     15
`define FPC_AUTOSAVE_CYC     (`FPC_AUTOSAVE_MIN * 40'd60 * 40'd100000000)
`endif

// ---- core/fpc_handler.v ----
// Purpose: failure-prediction command handler behind the task-file registers
// Assumes: host register strobes are one-cycle, synchronous to clk_i
// Notes:   medium and nonvolatile store are reached by request/ack ports
`include "fpc_map.vh"
`timescale 1ns/1ps
`default_nettype none
module fpc_handler #(
    parameter [39:0] AUTOSAVE_CYC = `FPC_AUTOSAVE_CYC,
    parameter [15:0] FORMAT_VER   = 16'h0001
) (
    input  wire        clk_i,
    input  wire        resetn_i,
    input  wire [9:0]  host_addr_i,
    input  wire        host_wr_i,
    input  wire        host_rd_i,
    input  wire [7:0]  host_wdata_i,
    output reg  [7:0]  host_rdata_o,
    output reg         intrq_o,
    output wire [7:0]  status_o,
    output reg         attr_rd_o,
    output reg  [4:0]  attr_idx_o,
    input  wire [7:0]  attr_id_i,
    input  wire [7:0]  attr_value_i,
    input  wire [7:0]  attr_worst_i,
    input  wire [7:0]  attr_thr_i,
    output reg         collect_en_o,
    output reg         medium_save_o,
    input  wire        medium_done_i,
    output reg         nv_write_o,
    output reg         nv_enable_o,
    output reg         nv_autosave_o,
    input  wire        nv_done_i,
    input  wire        nv_load_i,
    input  wire        nv_enable_i,
    input  wire        nv_autosave_i
);

localparam [2:0] S_IDLE  = 3'h0;
localparam [2:0] S_SAVE  = 3'h1;
localparam [2:0] S_NV    = 3'h2;
localparam [2:0] S_SCAN  = 3'h3;
localparam [2:0] S_XFER  = 3'h4;
localparam [2:0] S_DONE  = 3'h5;

reg  [7:0]  feature_sub_code;
reg  [7:0]  sector_count_arg;
reg  [7:0]  sector_number_arg;
reg  [7:0]  key_low_verdict;
reg  [7:0]  key_high_verdict;
reg  [7:0]  drive_select_head;
reg  [7:0]  err_reg;
reg         bsy;
reg         drq;
reg         err;
reg  [2:0]  state;
reg  [7:0]  sub;
reg         crossed;
reg  [8:0]  byte_ptr;
reg  [7:0]  csum;
reg  [39:0] save_timer;
reg         auto_pending;
reg         save_is_auto;
reg  [7:0]  next_byte;
reg  [4:0]  ent;
reg  [3:0]  pos;

// entry index in the upper five bits, byte inside the entry below
function [8:0] fpc_entry_split;
    input [8:0] r;
    reg   [8:0] q;
    reg   [8:0] m;
    begin
        q               = r / {5'h0, `FPC_ENTRY_LEN};
        m               = r % {5'h0, `FPC_ENTRY_LEN};
        fpc_entry_split = {q[4:0], m[3:0]};
    end
endfunction

function fpc_is_write;
    input [9:0] off;
    begin
        fpc_is_write = host_wr_i && (host_addr_i == off);
    end
endfunction

assign status_o = {bsy, ~bsy, 1'b0, 1'b0, drq, 1'b0, 1'b0, err};

////////////////////////////////////////////////////////////////////////////////
// block byte generator
always @* begin
    next_byte  = 8'h00;
    {ent, pos} = 9'h000;
    if (byte_ptr >= `FPC_ENTRY_FIRST && byte_ptr < `FPC_ENTRY_END) begin
        {ent, pos} = fpc_entry_split(byte_ptr - `FPC_ENTRY_FIRST);
    end
    attr_idx_o = ent;
    attr_rd_o  = (state == S_XFER) || (state == S_SCAN);
    if (byte_ptr == 9'h000) begin
        next_byte = FORMAT_VER[7:0];
    end else if (byte_ptr == 9'h001) begin
        next_byte = FORMAT_VER[15:8];
    end else if (byte_ptr < `FPC_ENTRY_END) begin
        case (pos)
            4'h0:    next_byte = attr_id_i;
            4'h1:    next_byte = (sub == `FPC_SUB_READ_ATTR) ? 8'h00 : attr_thr_i;
            4'h3:    next_byte = (sub == `FPC_SUB_READ_ATTR) ? attr_value_i : 8'h00;
            4'h4:    next_byte = (sub == `FPC_SUB_READ_ATTR) ? attr_worst_i : 8'h00;
            default: next_byte = 8'h00;
        endcase
    end else if (byte_ptr == `FPC_BLOCK_LAST) begin
        next_byte = 8'h00 - csum;
    end
end

////////////////////////////////////////////////////////////////////////////////
// host register reads
always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        host_rdata_o <= 8'h00;
    end else if (host_rd_i) begin
        case (host_addr_i)
            `FPC_OFF_DATA:     host_rdata_o <= drq ? next_byte : 8'h00;
            `FPC_OFF_FEATURE:  host_rdata_o <= err_reg;
            `FPC_OFF_SECT_CNT: host_rdata_o <= sector_count_arg;
            `FPC_OFF_SECT_NUM: host_rdata_o <= sector_number_arg;
            `FPC_OFF_KEY_LOW:  host_rdata_o <= key_low_verdict;
            `FPC_OFF_KEY_HIGH: host_rdata_o <= key_high_verdict;
            `FPC_OFF_DRV_HEAD: host_rdata_o <= drive_select_head;
            `FPC_OFF_COMMAND:  host_rdata_o <= status_o;
            default:           host_rdata_o <= 8'h00;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// command sequencer
always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        feature_sub_code  <= 8'h00;
        sector_count_arg  <= 8'h00;
        sector_number_arg <= 8'h00;
        key_low_verdict   <= 8'h00;
        key_high_verdict  <= 8'h00;
        drive_select_head <= 8'h00;
        err_reg           <= 8'h00;
        bsy               <= 1'b0;
        drq               <= 1'b0;
        err               <= 1'b0;
        intrq_o           <= 1'b0;
        state             <= S_IDLE;
        sub               <= 8'h00;
        crossed           <= 1'b0;
        byte_ptr          <= 9'h000;
        csum              <= 8'h00;
        collect_en_o      <= 1'b0;
        nv_autosave_o     <= 1'b0;
        nv_enable_o       <= 1'b0;
        nv_write_o        <= 1'b0;
        medium_save_o     <= 1'b0;
        save_timer        <= 40'h0;
        auto_pending      <= 1'b0;
        save_is_auto      <= 1'b0;
    end else begin
        if (host_rd_i && host_addr_i == `FPC_OFF_COMMAND) intrq_o <= 1'b0;
        if (nv_load_i) begin
            collect_en_o  <= nv_enable_i;
            nv_enable_o   <= nv_enable_i;
            nv_autosave_o <= nv_autosave_i;
        end
        if (collect_en_o && nv_autosave_o) begin
            if (save_timer >= AUTOSAVE_CYC - 40'h1) begin
                auto_pending <= 1'b1;
                save_timer   <= 40'h0;
            end else begin
                save_timer <= save_timer + 40'h1;
            end
        end else begin
            save_timer   <= 40'h0;
            auto_pending <= 1'b0;
        end
        if (!bsy && !drq) begin
            if (fpc_is_write(`FPC_OFF_FEATURE))  feature_sub_code  <= host_wdata_i;
            if (fpc_is_write(`FPC_OFF_SECT_CNT)) sector_count_arg  <= host_wdata_i;
            if (fpc_is_write(`FPC_OFF_SECT_NUM)) sector_number_arg <= host_wdata_i;
            if (fpc_is_write(`FPC_OFF_KEY_LOW))  key_low_verdict   <= host_wdata_i;
            if (fpc_is_write(`FPC_OFF_KEY_HIGH)) key_high_verdict  <= host_wdata_i;
            if (fpc_is_write(`FPC_OFF_DRV_HEAD)) drive_select_head <= host_wdata_i;
        end
        case (state)
            S_IDLE: begin
                if (!bsy && !drq && fpc_is_write(`FPC_OFF_COMMAND)) begin
                    err     <= 1'b0;
                    err_reg <= 8'h00;
                    intrq_o <= 1'b0;
                    bsy     <= 1'b1;
                    sub     <= feature_sub_code;
                    state   <= S_DONE;
                    if (host_wdata_i != `FPC_CMD_FAIL_PRED) begin
                        err <= 1'b1;
                        err_reg <= `FPC_ER_ABRT;
                    end else if (key_low_verdict != `FPC_KEY_LOW ||
                                 key_high_verdict != `FPC_KEY_HIGH) begin
                        err <= 1'b1;
                        err_reg <= `FPC_ER_ABRT;
                    end else if (!collect_en_o && feature_sub_code != `FPC_SUB_ENABLE) begin
                        err <= 1'b1;
                        err_reg <= `FPC_ER_ABRT;
                    end else begin
                        case (feature_sub_code)
                            `FPC_SUB_READ_ATTR, `FPC_SUB_SAVE_ATTR, `FPC_SUB_STATUS: begin
                                medium_save_o <= 1'b1;
                                state <= S_SAVE;
                            end
                            `FPC_SUB_READ_THR: begin
                                byte_ptr <= 9'h000;
                                csum     <= 8'h00;
                                state    <= S_XFER;
                            end
                            `FPC_SUB_AUTOSAVE: begin
                                nv_autosave_o <= (sector_count_arg != 8'h00);
                                nv_write_o    <= 1'b1;
                                state         <= S_NV;
                            end
                            `FPC_SUB_ENABLE: begin
                                nv_enable_o <= 1'b1;
                                nv_write_o  <= 1'b1;
                                state       <= S_NV;
                            end
                            `FPC_SUB_DISABLE: begin
                                nv_enable_o <= 1'b0;
                                nv_write_o  <= 1'b1;
                                state       <= S_NV;
                            end
                            default: begin
                                err     <= 1'b1;
                                err_reg <= `FPC_ER_ABRT;
                            end
                        endcase
                    end
                end else if (auto_pending && !bsy && !drq) begin
                    medium_save_o <= 1'b1;
                    save_is_auto  <= 1'b1;
                    bsy           <= 1'b1;
                    auto_pending  <= 1'b0;
                    state         <= S_SAVE;
                end
            end
            S_SAVE: begin
                if (medium_done_i) begin
                    medium_save_o <= 1'b0;
                    save_timer    <= 40'h0;
                    byte_ptr      <= (sub == `FPC_SUB_STATUS) ? `FPC_ENTRY_FIRST : 9'h000;
                    csum          <= 8'h00;
                    crossed       <= 1'b0;
                    if (save_is_auto) begin
                        save_is_auto <= 1'b0;
                        bsy          <= 1'b0;
                        state        <= S_IDLE;
                    end else if (sub == `FPC_SUB_READ_ATTR) begin
                        state <= S_XFER;
                    end else if (sub == `FPC_SUB_STATUS) begin
                        state <= S_SCAN;
                    end else begin
                        state <= S_DONE;
                    end
                end
            end
            S_NV: begin
                if (nv_done_i) begin
                    nv_write_o   <= 1'b0;
                    collect_en_o <= nv_enable_o;
                    state        <= S_DONE;
                end
            end
            S_SCAN: begin
                byte_ptr <= byte_ptr + {5'h0, `FPC_ENTRY_LEN};
                if (attr_id_i != 8'h00 && attr_value_i < attr_thr_i) begin
                    crossed <= 1'b1;
                end
                if (ent == `FPC_ENTRY_COUNT - 5'h1) begin
                    if (crossed || (attr_id_i != 8'h00 && attr_value_i < attr_thr_i)) begin
                        key_low_verdict  <= `FPC_BAD_LOW;
                        key_high_verdict <= `FPC_BAD_HIGH;
                    end else begin
                        key_low_verdict  <= `FPC_KEY_LOW;
                        key_high_verdict <= `FPC_KEY_HIGH;
                    end
                    state <= S_DONE;
                end
            end
            S_XFER: begin
                bsy <= 1'b0;
                drq <= 1'b1;
                if (!drq) intrq_o <= 1'b1;
                if (drq && host_rd_i && host_addr_i == `FPC_OFF_DATA) begin
                    csum     <= csum + next_byte;
                    byte_ptr <= byte_ptr + 9'h001;
                    if (byte_ptr == `FPC_BLOCK_LAST) begin
                        drq   <= 1'b0;
                        state <= S_IDLE;
                    end
                end
            end
            S_DONE: begin
                bsy     <= 1'b0;
                intrq_o <= 1'b1;
                state   <= S_IDLE;
            end
            default: state <= S_IDLE;
        endcase
    end
end

endmodule // fpc_handler
`default_nettype wire

// ---- bench/fpc_store_model.sv ----
// Purpose: attribute store, medium and nonvolatile store behind the handler
// Assumes: requests are levels held until the one-cycle done pulse
// Notes:   slow_i stretches both acknowledges from 1 to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module fpc_store_model (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic [4:0] attr_idx_i,
    input  wire logic       bad_en_i,
    input  wire logic [4:0] bad_idx_i,
    input  wire logic       slow_i,
    input  wire logic       medium_save_i,
    input  wire logic       nv_write_i,
    output logic      [7:0] attr_id_o,
    output logic      [7:0] attr_value_o,
    output logic      [7:0] attr_worst_o,
    output logic      [7:0] attr_thr_o,
    output logic            medium_done_o,
    output logic            nv_done_o
);
    logic [4:0] mc;
    logic [4:0] nc;
    logic [4:0] dly;
    assign dly = slow_i ? 5'h14 : 5'h01;
    // last entry unused, with a value that would fail if it were counted
    always_comb begin
        attr_id_o    = (attr_idx_i == 5'h1d) ? 8'h00 : {3'h0, attr_idx_i} + 8'h01;
        attr_value_o = (attr_idx_i == 5'h1d) ? 8'h00 : 8'h80 + {3'h0, attr_idx_i};
        if (bad_en_i && attr_idx_i == bad_idx_i)
            attr_value_o = 8'h10;
        attr_worst_o = 8'h70;
        attr_thr_o   = 8'h40;
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mc            <= 5'h00;
            nc            <= 5'h00;
            medium_done_o <= 1'b0;
            nv_done_o     <= 1'b0;
        end else begin
            medium_done_o <= medium_save_i && mc == dly;
            nv_done_o     <= nv_write_i && nc == dly;
            mc            <= medium_save_i ? mc + {4'h0, mc != 5'h1f} : 5'h00;
            nc            <= nv_write_i ? nc + {4'h0, nc != 5'h1f} : 5'h00;
        end
    end
endmodule // fpc_store_model
`default_nettype wire

// ---- bench/fpc_handler_asserts.sv ----
// Purpose: port assertions for the failure-prediction handler
// Assumes: status_o is {bsy,drdy,0,0,drq,0,0,err}
// Notes:   bound to fpc_handler at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module fpc_chk (
    input wire logic       clk_i,
    input wire logic       resetn_i,
    input wire logic [9:0] host_addr_i,
    input wire logic       host_wr_i,
    input wire logic [7:0] host_wdata_i,
    input wire logic       intrq_o,
    input wire logic [7:0] status_o,
    input wire logic       attr_rd_o,
    input wire logic [4:0] attr_idx_o,
    input wire logic       medium_save_o,
    input wire logic       medium_done_i,
    input wire logic       nv_write_o,
    input wire logic       nv_done_i,
    input wire logic       nv_enable_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    wire logic cmd_wr = host_wr_i && host_addr_i == 10'h1f7 && !status_o[7] && !status_o[3];
    property p_cmd_bsy; cmd_wr |=> status_o[7]; endproperty
    a_cmd_bsy: assert property (p_cmd_bsy) else $error("busy missing after command");
    property p_abort; cmd_wr && host_wdata_i != 8'hb0 |-> ##[1:4] (status_o[0] && !status_o[7]); endproperty
    a_abort: assert property (p_abort) else $error("foreign command not aborted");
    property p_done_irq; $fell(status_o[7]) && !$past(medium_save_o) |-> ##[0:2] intrq_o; endproperty
    a_done_irq: assert property (p_done_irq) else $error("no interrupt at completion");
    property p_med_hold; medium_save_o && !medium_done_i |=> medium_save_o; endproperty
    a_med_hold: assert property (p_med_hold) else $error("save request dropped early");
    property p_nv_hold; nv_write_o && !nv_done_i |=> nv_write_o; endproperty
    a_nv_hold: assert property (p_nv_hold) else $error("nv request dropped early");
    property p_bsy_drq; !(status_o[7] && status_o[3]); endproperty
    a_bsy_drq: assert property (p_bsy_drq) else $error("busy with data request");
    property p_idle_save; $rose(medium_save_o) && !$past(cmd_wr) |-> nv_enable_o; endproperty
    a_idle_save: assert property (p_idle_save) else $error("autosave while disabled");
    property p_idx; attr_rd_o |-> attr_idx_o <= 5'h1d; endproperty
    a_idx: assert property (p_idx) else $error("entry index past 29");
    c_cmd: cover property (cmd_wr);
    c_drq: cover property ($rose(status_o[3]));
    c_auto: cover property ($rose(medium_save_o) && !$past(cmd_wr));
endmodule // fpc_chk
bind fpc_handler fpc_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .host_addr_i(host_addr_i),
    .host_wr_i(host_wr_i), .host_wdata_i(host_wdata_i), .intrq_o(intrq_o), .status_o(status_o),
    .attr_rd_o(attr_rd_o), .attr_idx_o(attr_idx_o), .medium_save_o(medium_save_o),
    .medium_done_i(medium_done_i), .nv_write_o(nv_write_o), .nv_done_i(nv_done_i),
    .nv_enable_o(nv_enable_o));
`default_nettype wire

// ---- bench/fpc_handler_tb.sv ----
// Purpose: self-checking bench for the failure-prediction handler
// Assumes: autosave period shortened to 1000 cycles
// Notes:   host side driven at the falling edge
`timescale 1ns/1ps
`default_nettype none
module fpc_handler_tb;
    logic clk_i, resetn_i, host_wr_i, host_rd_i, nv_load_i, nv_enable_i, nv_autosave_i;
    logic [9:0] host_addr_i;
    logic [7:0] host_wdata_i, host_rdata_o, status_o, attr_id_i, attr_value_i, attr_worst_i, attr_thr_i;
    logic intrq_o, attr_rd_o, collect_en_o, medium_save_o, medium_done_i, nv_write_o, nv_enable_o;
    logic nv_autosave_o, nv_done_i, slow, bad_en, msv_q;
    logic [4:0] attr_idx_o, bad_idx;
    logic [7:0] b, s;
    logic [7:0] dis_subs [6] = '{8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd9, 8'hda};
    int seed = 28, error_cnt = 0, total_checks = 0, save_cnt = 0, n, i;
    fpc_handler #(.AUTOSAVE_CYC(40'd1000)) DUT (.clk_i, .resetn_i, .host_addr_i, .host_wr_i,
        .host_rd_i, .host_wdata_i, .host_rdata_o, .intrq_o, .status_o, .attr_rd_o, .attr_idx_o,
        .attr_id_i, .attr_value_i, .attr_worst_i, .attr_thr_i, .collect_en_o, .medium_save_o,
        .medium_done_i, .nv_write_o, .nv_enable_o, .nv_autosave_o, .nv_done_i, .nv_load_i,
        .nv_enable_i, .nv_autosave_i);
    fpc_store_model u_store (.clk_i, .resetn_i, .attr_idx_i(attr_idx_o), .bad_en_i(bad_en),
        .bad_idx_i(bad_idx), .slow_i(slow), .medium_save_i(medium_save_o), .nv_write_i(nv_write_o),
        .attr_id_o(attr_id_i), .attr_value_o(attr_value_i), .attr_worst_o(attr_worst_i),
        .attr_thr_o(attr_thr_i), .medium_done_o(medium_done_i), .nv_done_o(nv_done_i));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        msv_q <= medium_save_o;
        if (medium_save_o && !msv_q) save_cnt <= save_cnt + 1;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk_i);
        while (status_o[7]) @(negedge clk_i);
        host_addr_i = a;
        host_wdata_i = d;
        host_wr_i = 1'b1;
        @(negedge clk_i);
        host_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(negedge clk_i);
        host_addr_i = a;
        host_rd_i = 1'b1;
        @(negedge clk_i);
        host_rd_i = 1'b0;
        d = host_rdata_o;
    endtask
    // key loaded before every issue, as the host must
    task automatic cmd(input logic [7:0] c, sub, sc, kl, kh, input logic err);
        int t;
        logic [7:0] r;
        slow = 1'($random(seed));
        wr(10'h1f1, sub);
        wr(10'h1f2, sc);
        wr(10'h1f4, kl);
        wr(10'h1f5, kh);
        wr(10'h1f7, c);
        for (t = 0; t < 4000 && intrq_o !== 1'b1; t++) @(negedge clk_i);
        chk({7'h0, intrq_o}, 8'h01);
        chk({7'h0, status_o[0]}, {7'h0, err});
        rd(10'h1f7, r);
        if (err) rd(10'h1f1, r);
        if (err) chk(r, 8'h04);
    endtask
    task automatic read_block(input logic thr);
        int k, e, o;
        s = 8'h00;
        for (k = 0; k < 512; k++) begin
            rd(10'h1f0, b);
            s = s + b;
            if (k < 2) chk(b, (k == 0) ? 8'h01 : 8'h00);
            e = (k - 2) / 12;
            o = (k - 2) % 12;
            if (k >= 2 && k < 362 && o == 0) chk(b, (e == 29) ? 8'h00 : 8'(e + 1));
            if (k >= 2 && k < 362 && thr && o == 1) chk(b, 8'h40);
            if (k >= 2 && k < 362 && !thr && o == 3) chk(b, (e == 29) ? 8'h00 : 8'(8'h80 + e));
            if (k >= 2 && k < 362 && !thr && o == 4) chk(b, 8'h70);
        end
        chk(s, 8'h00);
        chk({7'h0, status_o[3]}, 8'h00);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #600000;
        error_cnt++;
        report_and_stop;
    end
    initial begin
        {resetn_i, host_wr_i, host_rd_i, nv_load_i, nv_enable_i, nv_autosave_i, bad_en, slow} = 8'h00;
        host_addr_i = 10'h000;
        host_wdata_i = 8'h00;
        bad_idx = 5'h00;
        repeat (6) @(negedge clk_i);
        resetn_i = 1'b1;
        @(negedge clk_i);
        chk({4'h0, intrq_o, medium_save_o, nv_write_o, collect_en_o}, 8'h00);
        nv_load_i = 1'b1;
        @(negedge clk_i);
        nv_load_i = 1'b0;
        foreach (dis_subs[j]) cmd(8'hb0, dis_subs[j], 8'h01, 8'h4f, 8'hc2, 1'b1);
        $display("test disabled done");
        cmd(8'hb0, 8'hd8, 8'h00, 8'h4f ^ 8'($random(seed) | 1), 8'hc2, 1'b1);
        cmd(8'hb0, 8'hd8, 8'h00, 8'h4f, 8'hc2 ^ 8'($random(seed) | 1), 1'b1);
        cmd(8'he0 | 8'($random(seed) & 15), 8'hd8, 8'h00, 8'h4f, 8'hc2, 1'b1);
        cmd(8'hb0, 8'hd8, 8'h00, 8'h4f, 8'hc2, 1'b0);
        chk({6'h0, nv_enable_o, collect_en_o}, 8'h03);
        for (i = 0; i < 4; i++) cmd(8'hb0, (i == 0) ? 8'hd4 : 8'he0 | 8'($random(seed) & 15), 8'h00, 8'h4f, 8'hc2, 1'b1);
        $display("test key and enable done");
        cmd(8'hb0, 8'hd2, 8'h00, 8'h4f, 8'hc2, 1'b0);
        chk({7'h0, nv_autosave_o}, 8'h00);
        cmd(8'hb0, 8'hd2, 8'($random(seed) | 1), 8'h4f, 8'hc2, 1'b0);
        chk({7'h0, nv_autosave_o}, 8'h01);
        n = save_cnt;
        repeat (2500) @(negedge clk_i);
        chk({7'h0, save_cnt >= n + 2}, 8'h01);
        $display("test autosave done");
        n = save_cnt;
        cmd(8'hb0, 8'hd3, 8'h00, 8'h4f, 8'hc2, 1'b0);
        chk({7'h0, save_cnt != n}, 8'h01);
        cmd(8'hb0, 8'hd1, 8'h00, 8'h4f, 8'hc2, 1'b0);
        read_block(1'b1);
        n = save_cnt;
        cmd(8'hb0, 8'hd0, 8'h00, 8'h4f, 8'hc2, 1'b0);
        chk({7'h0, save_cnt != n}, 8'h01);
        read_block(1'b0);
        $display("test blocks done");
        for (i = 0; i < 2; i++) begin
            bad_en = i[0];
            bad_idx = 5'($unsigned($random(seed)) % 29);
            n = save_cnt;
            cmd(8'hb0, 8'hda, 8'h00, 8'h4f, 8'hc2, 1'b0);
            chk({7'h0, save_cnt != n}, 8'h01);
            rd(10'h1f4, b);
            chk(b, bad_en ? 8'hf4 : 8'h4f);
            rd(10'h1f5, b);
            chk(b, bad_en ? 8'h2c : 8'hc2);
        end
        $display("test status done");
        cmd(8'hb0, 8'hd9, 8'h00, 8'h4f, 8'hc2, 1'b0);
        chk({6'h0, nv_enable_o, collect_en_o}, 8'h00);
        n = save_cnt;
        repeat (2500) @(negedge clk_i);
        chk(8'(save_cnt - n), 8'h00);
        $display("test disable done");
        report_and_stop;
    end
endmodule // fpc_handler_tb
`default_nettype wire
